// ===== rtl/reset_seq_pkg.sv
// shared constants and carriers for the reset source sequencer
// assumes a 100 MHz system clock and a 32-bit AHB-Lite register bus
package reset_seq_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // supply dip filter and pin glitch filter, least times, rounded up
  localparam int BOR_FILTER_NS = 1000;
  localparam int BOR_FILTER_CYC = (BOR_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIN_FILTER_NS = 300;
  localparam int PIN_FILTER_CYC = (PIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // power-up delay counted in low-frequency oscillator ticks
  localparam int PUT_DELAY_MS = 64;
  localparam int LF_OSC_HZ = 31000;
  localparam int PUT_TICKS = PUT_DELAY_MS * LF_OSC_HZ / 1000;
  localparam int EVENT_HOLD_CYC = 4;
  localparam int FILT_CNT_W = 8;
  localparam int PUT_CNT_W = 11;

  localparam logic [7:0] ADDR_BROWNOUT_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_RESET_CAUSE = 8'h04;
  localparam logic [7:0] ADDR_CORE_STATUS = 8'h08;
  localparam logic [7:0] ADDR_PIN_CONTROL = 8'h0c;

  localparam int BIT_SW_BOR_EN = 7;
  localparam int BIT_BANDGAP_HOLD = 6;
  localparam int BIT_BOR_READY = 0;
  localparam int BIT_TIMEOUT_N = 1;
  localparam int BIT_POWERDOWN_N = 0;
  localparam int BIT_PULLUP = 0;

  localparam logic [1:0] BOR_MODE_OFF = 2'h0;
  localparam logic [1:0] BOR_MODE_SW = 2'h1;
  localparam logic [1:0] BOR_MODE_NOSLEEP = 2'h2;
  localparam logic [1:0] BOR_MODE_ON = 2'h3;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic delay_timer_enable_n;
    logic [1:0] brownout_mode_sel;
    logic low_power_brownout_en;
    logic config_erased;
    logic ext_reset_pin_enable;
    logic low_voltage_prog_enable;
    logic stack_reset_enable;
  } reset_cfg_t;

  typedef struct packed {
    logic stack_overflow_flag;
    logic stack_underflow_flag;
    logic unused_bit;
    logic watchdog_reset_flag_n;
    logic pin_reset_flag_n;
    logic reset_instr_flag_n;
    logic power_on_flag_n;
    logic brownout_flag_n;
  } cause_flags_t;

  localparam cause_flags_t CAUSE_RESET = 8'h1c;
  localparam logic SW_BOR_EN_RESET = 1'b1;
  localparam logic BANDGAP_HOLD_RESET = 1'b0;
  localparam logic PULLUP_RESET = 1'b0;

  typedef enum {ST_SUPPLY, ST_DELAY, ST_START, ST_EVENT, ST_RUN} seq_state_t;
endpackage

// ===== rtl/reset_source_sequencer.sv
// reset source combiner, power-up delay and start-up sequencer
// assumes synchronous inputs, i_lf_tick one cycle per low-frequency
// oscillator period, and analog detectors outside this block
//
// Local design decisions: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module reset_source_sequencer #(
  parameter int PUT_TICKS_P = reset_seq_pkg::PUT_TICKS,
  parameter int BOR_FILT_P = reset_seq_pkg::BOR_FILTER_CYC,
  parameter int PIN_FILT_P = reset_seq_pkg::PIN_FILTER_CYC
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire reset_seq_pkg::reset_cfg_t i_cfg,
  input wire logic i_por_req,
  input wire logic i_supply_below,
  input wire logic i_bor_circuit_ready,
  input wire logic i_low_power_brownout_detect,
  input wire logic i_ext_reset_pin_n,
  input wire logic i_wdt_timeout,
  input wire logic i_wdt_clear,
  input wire logic i_reset_instr,
  input wire logic i_stack_overflow,
  input wire logic i_stack_underflow,
  input wire logic i_prog_mode_exit,
  input wire logic i_sleep,
  input wire logic i_lf_tick,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic o_core_reset_n,
  output logic o_wake_allow,
  output logic o_brownout_detect_en,
  output logic o_bandgap_force_on,
  output logic o_pin_gp_mode,
  output logic o_pin_pullup_en
);
  import reset_seq_pkg::*;

  localparam int FILT_N = 2;
  localparam int F_BOR = 0;
  localparam int F_PIN = 1;

  seq_state_t state_reg, state_next;
  cause_flags_t cause_reg;
  logic sw_bor_en_reg, bandgap_hold_reg, pullup_reg;
  logic timeout_n_reg, powerdown_n_reg, sleep_d_reg;
  logic [PUT_CNT_W-1:0] put_cnt_reg;
  logic [2:0] event_cnt_reg;
  logic [FILT_N-1:0] filt_raw, filt_out;
  logic [FILT_N*FILT_CNT_W-1:0] filt_lim;
  logic bor_active, bor_req, low_power_brownout_req, bor_any, supply_rst, pin_en;
  logic pin_low, start_ok, event_req, put_done;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;

  // detection enable per mode
  always_comb begin
    unique case (i_cfg.brownout_mode_sel)
      BOR_MODE_ON: bor_active = 1'b1;
      BOR_MODE_NOSLEEP: bor_active = !i_sleep;
      BOR_MODE_SW: bor_active = sw_bor_en_reg;
      BOR_MODE_OFF: bor_active = 1'b0;
    endcase
  end

  // one dip/glitch filter per channel; output flips only after a steady run
  assign filt_raw[F_BOR] = i_supply_below;
  assign filt_raw[F_PIN] = !i_ext_reset_pin_n;
  assign filt_lim[F_BOR*FILT_CNT_W +: FILT_CNT_W] = FILT_CNT_W'(BOR_FILT_P);
  assign filt_lim[F_PIN*FILT_CNT_W +: FILT_CNT_W] = FILT_CNT_W'(PIN_FILT_P);
  genvar g;
  generate
    for (g = 0; g < FILT_N; g++) begin : g_filt
      logic [FILT_CNT_W-1:0] cnt_reg;
      logic out_reg;
      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          cnt_reg <= '0;
          out_reg <= 1'b0;
        end else if (filt_raw[g] == out_reg) begin
          cnt_reg <= '0;
        end else if (cnt_reg >= filt_lim[g*FILT_CNT_W +: FILT_CNT_W] - 1'b1) begin
          cnt_reg <= '0;
          out_reg <= filt_raw[g];
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
      assign filt_out[g] = out_reg;
    end
  endgenerate

  // dip protection begins only once the circuit reports ready; the low-power brown-out path does not wait for it
  assign bor_req = filt_out[F_BOR] && bor_active && i_bor_circuit_ready;
  assign low_power_brownout_req = i_low_power_brownout_detect && i_cfg.low_power_brownout_en
    && !i_cfg.config_erased;
  assign bor_any = bor_req || low_power_brownout_req;
  assign supply_rst = i_por_req || bor_any || i_prog_mode_exit;
  assign pin_en = i_cfg.low_voltage_prog_enable || i_cfg.ext_reset_pin_enable;
  assign pin_low = pin_en && filt_out[F_PIN];
  assign put_done = put_cnt_reg >= PUT_CNT_W'(PUT_TICKS_P);
  assign event_req = i_wdt_timeout || i_reset_instr
    || (i_cfg.stack_reset_enable && (i_stack_overflow || i_stack_underflow));

  // modes 11 and 10 wait for readiness and a healthy supply; 01 and 00 do not
  assign start_ok = !i_cfg.brownout_mode_sel[1]
    || (i_bor_circuit_ready && !filt_out[F_BOR]);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_SUPPLY: begin
        if (!supply_rst) begin
          state_next = i_cfg.delay_timer_enable_n ? ST_START : ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (put_done) begin
          state_next = ST_START;
        end
      end
      ST_START: begin
        if (start_ok && !pin_low) begin
          state_next = ST_RUN;
        end
      end
      ST_EVENT: begin
        if (event_cnt_reg == 3'(EVENT_HOLD_CYC - 1)) begin
          state_next = ST_START;
        end
      end
      ST_RUN: begin
        if (pin_low) begin
          state_next = ST_START;
        end else if (event_req) begin
          state_next = ST_EVENT;
        end
      end
    endcase
    if (supply_rst) begin
      state_next = ST_SUPPLY;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= ST_SUPPLY;
      o_core_reset_n <= 1'b0;
    end else begin
      state_reg <= state_next;
      o_core_reset_n <= state_next == ST_RUN;
    end
  end

  // power-up delay counter, advanced by low-frequency ticks only
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      put_cnt_reg <= '0;
    end else if (state_reg != ST_DELAY || supply_rst) begin
      put_cnt_reg <= '0;
    end else if (i_lf_tick && !put_done) begin
      put_cnt_reg <= put_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      event_cnt_reg <= '0;
    end else if (state_reg == ST_EVENT) begin
      event_cnt_reg <= event_cnt_reg + 1'b1;
    end else begin
      event_cnt_reg <= '0;
    end
  end

  // pads and analog controls
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_brownout_detect_en <= 1'b0;
      o_bandgap_force_on <= 1'b0;
      o_pin_gp_mode <= 1'b0;
      o_pin_pullup_en <= 1'b1;
      o_wake_allow <= 1'b0;
    end else begin
      o_brownout_detect_en <= bor_active;
      o_bandgap_force_on <= bandgap_hold_reg
        && (i_cfg.brownout_mode_sel == BOR_MODE_NOSLEEP
        || i_cfg.brownout_mode_sel == BOR_MODE_SW);
      o_pin_gp_mode <= !pin_en;
      o_pin_pullup_en <= pin_en || pullup_reg;
      // only mode 10 holds back wake-up until the circuit is ready
      o_wake_allow <= i_cfg.brownout_mode_sel != BOR_MODE_NOSLEEP
        || i_bor_circuit_ready;
    end
  end

  // ahb-lite slave: zero wait states, always okay
  logic addr_ok;
  logic [7:0] rd_sel;
  logic [31:0] rd_data;
  assign addr_ok = i_hsel && i_hready && i_htrans == HTRANS_NONSEQ;
  assign rd_sel = i_haddr[7:0];

  always_comb begin
    rd_data = '0;
    if (i_haddr[31:8] == 24'h000000) begin
      unique case (rd_sel)
        ADDR_BROWNOUT_CONTROL: begin
          rd_data[BIT_SW_BOR_EN] = sw_bor_en_reg;
          rd_data[BIT_BANDGAP_HOLD] = bandgap_hold_reg;
          rd_data[BIT_BOR_READY] = bor_active && i_bor_circuit_ready;
        end
        ADDR_RESET_CAUSE: rd_data[7:0] = {cause_reg[7:6], 1'b0, cause_reg[4:0]};
        ADDR_CORE_STATUS: begin
          rd_data[BIT_TIMEOUT_N] = timeout_n_reg;
          rd_data[BIT_POWERDOWN_N] = powerdown_n_reg;
        end
        ADDR_PIN_CONTROL: rd_data[BIT_PULLUP] = pullup_reg;
        default: rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_hrdata <= '0;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      if (addr_ok && !i_hwrite) begin
        o_hrdata <= rd_data;
      end
      wr_pend_reg <= addr_ok && i_hwrite && i_haddr[31:8] == 24'h000000;
      if (addr_ok) begin
        wr_addr_reg <= rd_sel;
      end
    end
  end

  logic wr_bor, wr_cause, wr_pin;
  assign wr_bor = wr_pend_reg && wr_addr_reg == ADDR_BROWNOUT_CONTROL;
  assign wr_cause = wr_pend_reg && wr_addr_reg == ADDR_RESET_CAUSE;
  assign wr_pin = wr_pend_reg && wr_addr_reg == ADDR_PIN_CONTROL;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sw_bor_en_reg <= SW_BOR_EN_RESET;
      bandgap_hold_reg <= BANDGAP_HOLD_RESET;
      pullup_reg <= PULLUP_RESET;
    end else begin
      if (wr_bor) begin
        sw_bor_en_reg <= i_hwdata[BIT_SW_BOR_EN];
        bandgap_hold_reg <= i_hwdata[BIT_BANDGAP_HOLD];
      end
      if (wr_pin) begin
        pullup_reg <= i_hwdata[BIT_PULLUP];
      end
    end
  end

  // cause flags: software write first, hardware events override it
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cause_reg <= CAUSE_RESET;
    end else begin
      if (wr_cause) begin
        cause_reg <= i_hwdata[7:0];
      end
      if (i_por_req || i_prog_mode_exit) begin
        cause_reg <= CAUSE_RESET;
      end else if (bor_any) begin
        cause_reg.stack_overflow_flag <= 1'b0;
        cause_reg.stack_underflow_flag <= 1'b0;
        cause_reg.pin_reset_flag_n <= 1'b1;
        cause_reg.reset_instr_flag_n <= 1'b1;
        cause_reg.brownout_flag_n <= 1'b0;
      end else if (state_reg == ST_RUN) begin
        if (pin_low) begin
          cause_reg.pin_reset_flag_n <= 1'b0;
        end else begin
          if (i_wdt_timeout) begin
            cause_reg.watchdog_reset_flag_n <= 1'b0;
          end
          if (i_reset_instr) begin
            cause_reg.reset_instr_flag_n <= 1'b0;
          end
          if (i_cfg.stack_reset_enable && i_stack_overflow) begin
            cause_reg.stack_overflow_flag <= 1'b1;
          end
          if (i_cfg.stack_reset_enable && i_stack_underflow) begin
            cause_reg.stack_underflow_flag <= 1'b1;
          end
        end
      end
    end
  end

  // timeout and powerdown status bits
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      timeout_n_reg <= 1'b1;
      powerdown_n_reg <= 1'b1;
      sleep_d_reg <= 1'b0;
    end else begin
      sleep_d_reg <= i_sleep;
      if (i_por_req || i_prog_mode_exit) begin
        timeout_n_reg <= 1'b1;
        powerdown_n_reg <= 1'b1;
      end else if (i_wdt_timeout) begin
        timeout_n_reg <= 1'b0;
        powerdown_n_reg <= !i_sleep;
      end else if (i_wdt_clear) begin
        timeout_n_reg <= 1'b1;
        powerdown_n_reg <= 1'b1;
      end else if (i_sleep && !sleep_d_reg) begin
        timeout_n_reg <= 1'b1;
        powerdown_n_reg <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  a_supply_holds_core: assert property (supply_rst |=> !o_core_reset_n)
    else $error("core left running during supply reset");
  a_delay_holds_core: assert property (state_reg == ST_DELAY |-> !o_core_reset_n)
    else $error("core running while delay active");
  a_delay_skipped_off: assert property (
    state_reg == ST_SUPPLY && !supply_rst && i_cfg.delay_timer_enable_n
    |=> state_reg != ST_DELAY)
    else $error("delay inserted while disabled");
  a_delay_after_release: assert property (supply_rst |=> put_cnt_reg == '0)
    else $error("delay counted during supply reset");
  a_off_mode_no_detect: assert property (
    i_cfg.brownout_mode_sel == BOR_MODE_OFF |=> !o_brownout_detect_en)
    else $error("detection on in off mode");
  a_start_waits_ready: assert property (
    state_reg == ST_START && i_cfg.brownout_mode_sel[1] && !i_bor_circuit_ready
    |=> !o_core_reset_n)
    else $error("start did not wait for ready");
  a_bandgap_ignored: assert property (
    i_cfg.brownout_mode_sel == BOR_MODE_ON |=> !o_bandgap_force_on)
    else $error("band-gap forced in always-on mode");
  a_low_power_brownout_flag: assert property (
    low_power_brownout_req && !i_por_req && !i_prog_mode_exit
    |=> !cause_reg.brownout_flag_n && !o_core_reset_n)
    else $error("low-power brown-out not recorded");
  a_pin_reset_flag: assert property (
    state_reg == ST_RUN && pin_low && !supply_rst
    |=> !cause_reg.pin_reset_flag_n ##0 !o_core_reset_n)
    else $error("pin reset not taken");
  a_instr_reset: assert property (
    state_reg == ST_RUN && !pin_low && !supply_rst && i_reset_instr
    |=> !cause_reg.reset_instr_flag_n ##1 !o_core_reset_n[*3])
    else $error("reset instruction not taken");
  a_wdt_flags: assert property (
    i_wdt_timeout && !i_por_req && !i_prog_mode_exit |=> !timeout_n_reg)
    else $error("watchdog timeout not recorded");
  a_pin_release_start: assert property (
    state_reg == ST_START && start_ok && !pin_low && !supply_rst
    |=> o_core_reset_n)
    else $error("start late after pin release");

  c_delay_done: cover property (state_reg == ST_DELAY ##1 state_reg == ST_START);
  c_event_reset: cover property (state_reg == ST_EVENT ##[1:8] state_reg == ST_RUN);
  c_pin_hold: cover property (state_reg == ST_START && pin_low
    ##1 state_reg == ST_START && !pin_low ##1 o_core_reset_n);
endmodule

// ===== verif/supply_model.sv
// behavioural far side: supply monitors, reset pin and low-frequency oscillator
// assumes the bench steers the analog conditions through the i_ controls
`timescale 1ns/1ps
module supply_model #(
  parameter int TICK_DIV = 8,
  parameter int READY_DLY = 6
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_por,
  input wire logic i_dip,
  input wire logic i_lp,
  input wire logic i_pin_low,
  input wire logic i_unready,
  output logic o_por_req,
  output logic o_supply_below,
  output logic o_ready,
  output logic o_low_power_brownout,
  output logic o_pin_n,
  output logic o_lf_tick
);
  int div;
  int rc;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div <= 0;
      o_lf_tick <= 1'b0;
    end else begin
      div <= (div == TICK_DIV - 1) ? 0 : div + 1;
      o_lf_tick <= (div == TICK_DIV - 1);
    end
  end
  // circuit needs time to come up after each power-on request (i_por); dips and low-power events do not restart it
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rc <= 0;
    end else if (i_por) begin
      rc <= 0;
    end else if (rc < READY_DLY) begin
      rc <= rc + 1;
    end
  end
  assign o_ready = (rc == READY_DLY) && !i_unready;
  assign o_por_req = i_por;
  assign o_supply_below = i_dip;
  assign o_low_power_brownout = i_lp;
  // weak pull-up: a released pin reads high
  assign o_pin_n = i_pin_low ? 1'b0 : 1'b1;
endmodule

// ===== verif/reset_source_sequencer_tb_top.sv
// self-checking bench for the reset source sequencer
// assumes zero-wait AHB-Lite slave and shortened count parameters
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module reset_source_sequencer_tb_top;
  import reset_seq_pkg::*;
  localparam int PT = 4;
  localparam int DIV = 8;
  typedef struct {int k; logic [31:0] e; string nm;} note_t;
  note_t q[$];
  note_t n;
  int num_errors = 0;
  int cmp_count = 0;
  int r;
  logic i_clk = 0;
  logic i_resetn = 0;
  reset_cfg_t cfg = '0;
  logic por = 0, dip = 0, lp = 0, pin_low = 0, unready = 0, slp = 0;
  logic [5:0] ev = '0;
  logic hsel = 0, hwrite = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic por_req, below, rdy, low_power_brownout, pin_n, tick, hrdy, hresp;
  logic core_n, wake, det, bg, gp, pu;
  initial forever #5 i_clk = ~i_clk;
  supply_model #(.TICK_DIV(DIV), .READY_DLY(6)) partner (.i_clk(i_clk),
    .i_resetn(i_resetn), .i_por(por), .i_dip(dip), .i_lp(lp), .i_pin_low(pin_low),
    .i_unready(unready), .o_por_req(por_req), .o_supply_below(below), .o_ready(rdy),
    .o_low_power_brownout(low_power_brownout), .o_pin_n(pin_n), .o_lf_tick(tick));
  reset_source_sequencer #(.PUT_TICKS_P(PT), .BOR_FILT_P(3), .PIN_FILT_P(3)) dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_cfg(cfg), .i_por_req(por_req),
    .i_supply_below(below), .i_bor_circuit_ready(rdy), .i_low_power_brownout_detect(low_power_brownout),
    .i_ext_reset_pin_n(pin_n), .i_wdt_timeout(ev[0]), .i_wdt_clear(ev[1]),
    .i_reset_instr(ev[2]), .i_stack_overflow(ev[3]), .i_stack_underflow(ev[4]),
    .i_prog_mode_exit(ev[5]), .i_sleep(slp), .i_lf_tick(tick), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy),
    .o_hresp(hresp), .o_core_reset_n(core_n), .o_wake_allow(wake),
    .o_brownout_detect_en(det), .o_bandgap_force_on(bg), .o_pin_gp_mode(gp),
    .o_pin_pullup_en(pu));
  function automatic logic [31:0] seen(input int k);
    case (k)
      0: seen = hrdata;
      1: seen = {31'h0, core_n};
      2: seen = {31'h0, gp};
      3: seen = {31'h0, pu};
      4: seen = {31'h0, det};
      5: seen = {31'h0, bg};
      6: seen = {31'h0, wake};
      default: seen = {31'h0, hresp};
    endcase
  endfunction
  // scoreboard: results are settled by the falling edge
  always @(negedge i_clk) begin
    while (q.size() > 0) begin
      n = q.pop_front();
      `CHK(n.nm, n.e, seen(n.k))
    end
  end
  task automatic note(input int k, input logic [31:0] e, input string nm);
    q.push_back('{k, e, nm});
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge i_clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge i_clk); while (hrdy !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    note(0, e, "hrdata");
    note(7, 32'h0, "hresp");
  endtask
  task automatic pulse(input int i);
    @(posedge i_clk);
    ev[i] <= 1'b1;
    @(posedge i_clk);
    ev[i] <= 1'b0;
  endtask
  task automatic wc(input logic e, input int lim);
    int c;
    c = 0;
    @(negedge i_clk);
    while (core_n !== e && c < lim) begin
      @(negedge i_clk);
      c++;
    end
    note(1, {31'h0, e}, "core_reset_n");
    // hand back on a rising edge so the next stimulus lands there
    @(posedge i_clk);
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge i_clk);
    @(posedge i_clk);
  endtask
  task automatic power(input int hold);
    @(posedge i_clk);
    por <= 1'b1;
    repeat (hold) @(posedge i_clk);
    por <= 1'b0;
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #100us;
    num_errors++;
    final_report();
  end
  initial begin
    cfg.brownout_mode_sel = BOR_MODE_ON;
    cfg.low_power_brownout_en = 1'b1;
    cfg.ext_reset_pin_enable = 1'b1;
    cfg.stack_reset_enable = 1'b1;
    r = $urandom(32'hee8a);
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'b1;
    power(4);
    cyc(PT * DIV - DIV);
    note(1, 0, "core_reset_n");
    wc(1, 40);
    rd(ADDR_RESET_CAUSE, 32'h1c);
    rd(ADDR_BROWNOUT_CONTROL, 32'h81);
    xfer(1'b1, ADDR_RESET_CAUSE, 32'hff);
    rd(ADDR_RESET_CAUSE, 32'hdf);
    r = $urandom() & 32'hc0;
    xfer(1'b1, ADDR_BROWNOUT_CONTROL, r | 32'h3f);
    rd(ADDR_BROWNOUT_CONTROL, r | 32'h1);
    xfer(1'b1, ADDR_BROWNOUT_CONTROL, 32'h80);
    xfer(1'b1, 8'h40, 32'hff);
    rd(8'h40, 32'h0);
    for (int i = 0; i < 6; i++) begin
      if (i == 1 || i == 5) continue;
      xfer(1'b1, ADDR_RESET_CAUSE, 32'h1f);
      pulse(i);
      wc(0, 4);
      wc(1, 20);
      rd(ADDR_RESET_CAUSE, i == 0 ? 32'h0f : i == 2 ? 32'h1b : i == 3 ? 32'h9f : 32'h5f);
    end
    rd(ADDR_CORE_STATUS, 32'h1);
    pulse(1);
    rd(ADDR_CORE_STATUS, 32'h3);
    cfg.stack_reset_enable <= 1'b0;
    pulse(3);
    cyc(5);
    note(1, 1, "core_reset_n");
    cfg.stack_reset_enable <= 1'b1;
    xfer(1'b1, ADDR_RESET_CAUSE, 32'h1f);
    @(posedge i_clk);
    pin_low <= 1'b1;
    repeat ($urandom_range(1, 2)) @(posedge i_clk);
    pin_low <= 1'b0;
    cyc(5);
    note(1, 1, "core_reset_n");
    pin_low <= 1'b1;
    wc(0, 10);
    rd(ADDR_RESET_CAUSE, 32'h17);
    pin_low <= 1'b0;
    wc(1, 20);
    cfg.ext_reset_pin_enable <= 1'b0;
    pin_low <= 1'b1;
    for (int v = 1; v >= 0; v--) begin
      xfer(1'b1, ADDR_PIN_CONTROL, v);
      cyc(2);
      note(3, v, "pullup_en");
    end
    note(2, 1, "gp_mode");
    note(1, 1, "core_reset_n");
    pin_low <= 1'b0;
    cfg.low_voltage_prog_enable <= 1'b1;
    cyc(3);
    note(2, 0, "gp_mode");
    cfg.low_voltage_prog_enable <= 1'b0;
    cfg.ext_reset_pin_enable <= 1'b1;
    pin_low <= 1'b1;
    power(4);
    cyc(60);
    note(1, 0, "core_reset_n");
    pin_low <= 1'b0;
    wc(1, 7);
    cfg.delay_timer_enable_n <= 1'b1;
    power(4);
    wc(0, 3);
    wc(1, 12);
    cfg.delay_timer_enable_n <= 1'b0;
    xfer(1'b1, ADDR_RESET_CAUSE, 32'h1f);
    @(posedge i_clk);
    dip <= 1'b1;
    repeat (2) @(posedge i_clk);
    dip <= 1'b0;
    cyc(5);
    note(1, 1, "core_reset_n");
    dip <= 1'b1;
    wc(0, 8);
    dip <= 1'b0;
    wc(1, 60);
    rd(ADDR_RESET_CAUSE, 32'h1e);
    xfer(1'b1, ADDR_RESET_CAUSE, 32'h1f);
    lp <= 1'b1;
    wc(0, 4);
    lp <= 1'b0;
    wc(1, 60);
    rd(ADDR_RESET_CAUSE, 32'h1e);
    cfg.config_erased <= 1'b1;
    lp <= 1'b1;
    cyc(6);
    note(1, 1, "core_reset_n");
    lp <= 1'b0;
    cfg.config_erased <= 1'b0;
    xfer(1'b1, ADDR_RESET_CAUSE, 32'hff);
    pulse(5);
    wc(0, 4);
    wc(1, 60);
    rd(ADDR_RESET_CAUSE, 32'h1c);
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 4; s++) begin
        cfg.brownout_mode_sel <= 2'(m);
        slp <= s[0];
        xfer(1'b1, ADDR_BROWNOUT_CONTROL, {s[1], 7'h40});
        cyc(3);
        note(4, m == 3 || (m == 2 && !s[0]) || (m == 1 && s[1]), "detect_en");
        note(5, m == 1 || m == 2, "bandgap_on");
      end
    end
    for (int m = 2; m < 4; m++) begin
      cfg.brownout_mode_sel <= 2'(m);
      unready <= 1'b1;
      cyc(3);
      note(6, m == 3, "wake_allow");
    end
    unready <= 1'b0;
    slp <= 1'b0;
    cyc(3);
    note(6, 1, "wake_allow");
    cyc(2);
    final_report();
  end
endmodule
